// *** src/bioc_pkg.sv ***
package bioc_pkg;

    // ------------------------------------------------------------
    // Widths and field positions.
    // ------------------------------------------------------------
    localparam int WORD_W   = 24;
    localparam int DWORD_W  = 48;
    localparam int ADDR_W   = 20;
    localparam int PAR_W    = 16;
    localparam int WCNT_W   = 16;
    localparam int SKIP_W   = 8;
    localparam int STAT_W   = 8;
    localparam int CNT_W    = 16;
    localparam int BLOCK_BIT = 23;
    localparam int DIR_BIT   = 22;
    localparam int TOP_HI    = 23;
    localparam int TOP_LO    = 22;
    localparam int SKIP_LO   = 16;
    localparam logic [1:0] TERM_DATA = 2'h2;
    localparam logic [1:0] TERM_CMD  = 2'h3;

    // ------------------------------------------------------------
    // Register map: index per channel window, channel in address bit 5.
    // ------------------------------------------------------------
    localparam int CHAN_BIT = 5;
    localparam int IDX_HI   = 4;
    localparam int IDX_LO   = 2;
    localparam logic [2:0] REG_CMD    = 3'h0;
    localparam logic [2:0] REG_ODATA  = 3'h1;
    localparam logic [2:0] REG_PADDR  = 3'h2;
    localparam logic [2:0] REG_IDATA  = 3'h3;
    localparam logic [2:0] REG_ISTAT  = 3'h4;
    localparam logic [2:0] REG_CHSTAT = 3'h5;
    localparam logic [31:0] REFUSED   = 32'h8000_0000;

    // ------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------
    localparam int CLK_MHZ    = 25;
    localparam int SCAN_NS    = 2000;
    localparam int TIMEOUT_NS = 20000;
    localparam int SLOT_CYC   = (SCAN_NS * CLK_MHZ + 999) / 1000;
    localparam int TMO_CYC    = TIMEOUT_NS * CLK_MHZ / 1000;

    // ------------------------------------------------------------
    // Channel sequencer states.
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE   = 9'b000000001,
        ST_SCMD   = 9'b000000010,
        ST_FCMD   = 9'b000000100,
        ST_FP1    = 9'b000001000,
        ST_FP2    = 9'b000010000,
        ST_OFETCH = 9'b000100000,
        ST_OSEND  = 9'b001000000,
        ST_IGATH  = 9'b010000000,
        ST_ISTORE = 9'b100000000
    } bioc_state_e;

    typedef struct packed {
        logic              dataAvail;
        logic              accepted;
        logic              statusValid;
        logic [WORD_W-1:0] data;
    } bioc_unit_in_s;

    typedef struct packed {
        logic              chanSel;
        logic              dataAccepted;
        logic              dataHere;
        logic              cmdHere;
        logic [WORD_W-1:0] data;
    } bioc_unit_out_s;

    typedef struct packed {
        logic               req;
        logic               we;
        logic               dbl;
        logic [ADDR_W-1:0]  addr;
        logic [DWORD_W-1:0] wdata;
    } bioc_mem_out_s;

    typedef struct packed {
        logic               grant;
        logic               prioIn;
        logic [DWORD_W-1:0] rdata;
    } bioc_mem_in_s;

endpackage

// *** src/bioc_channel.sv ***
// How it works
// - Input-data instruction is refused until unit data-available was seen.
// - Single input word goes to CPU, then data-accepted until unit drops it.
// - Block input latches unit word on data-available and raises accepted.
// - After latching the second word of a pair or the last word, a store cycle is requested; no new word until done.
// - Two logical channels share the unit bus in alternating scan slots.
// - A channel uses the bus only in its slot; handshakes stretch it.
// - Status-ready needs status or data in both last two own slots.
// - Input-status returns captured status with no unit handshake.
// - Latched data goes to CPU; acceptance follows once the channel owns the slot.
// - Block data moves as 48-bit double words, two unit words each.
// - Grant reaches only the highest priority requesting channel.
// - Command with bit 23 set starts block mode and parameter fetch.
// - Address-word instruction loads the 16-bit parameter address.
// - Parameter address increments after every parameter fetch.
// - Parameter one holds skip count on top, word count below.
// - Nonzero skip count drops input words without storing them.
// - Parameter two holds transfer address and two termination bits.
// - Termination 00/01 ends, 10 data chains, 11 command chains.
// - Normal termination goes not-busy after the last word.
// - Data restart fetches two parameters and keeps the direction.
// - Command chain fetches a command, sends it, then parameters.
// - Chained command without bit 23 ends not-busy once sent.
// - Chain list is command then two parameters; top bits give direction.
// - Single output loads buffer, raises here line, busy until accepted.
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bioc_channel #(
    parameter int NCH      = 2,
    parameter int SLOT_CYC = bioc_pkg::SLOT_CYC,
    parameter int TMO_CYC  = bioc_pkg::TMO_CYC
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire bioc_pkg::bioc_unit_in_s unitIn,
    output bioc_pkg::bioc_unit_out_s    unitOut,
    input  wire bioc_pkg::bioc_mem_in_s memIn,
    output bioc_pkg::bioc_mem_out_s     memOut,
    output logic                        prioOut
);
    import bioc_pkg::*;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    localparam logic [CNT_W-1:0] SLOT_END = CNT_W'(SLOT_CYC - 1);
    localparam logic [CNT_W-1:0] SLOT_MAX = CNT_W'(SLOT_CYC + TMO_CYC - 1);

    function automatic logic regOp(input logic [7:0] adr, input int ch,
                                   input logic [2:0] idx);
        regOp = (adr[CHAN_BIT] == ch[0]) && (adr[IDX_HI:IDX_LO] == idx)
              && (adr[7:6] == 2'h0);
    endfunction

    // ------------------------------------------------------------
    // Unit bus synchroniser.
    // ------------------------------------------------------------
    bioc_unit_in_s uS1_q;
    bioc_unit_in_s uS2_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            uS1_q <= '0;
            uS2_q <= '0;
        end else begin
            uS1_q <= unitIn;
            uS2_q <= uS1_q;
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave.
    // ------------------------------------------------------------
    logic ack_q;
    logic wbTake;
    logic wbWr;
    logic wbRd;
    assign wbTake   = wb_cyc_i && wb_stb_i && !ack_q;
    assign wbWr     = wbTake && wb_we_i && (wb_sel_i != 4'h0);
    assign wbRd     = wbTake && !wb_we_i;
    assign wb_ack_o = ack_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) ack_q <= 1'b0;
        else     ack_q <= wbTake;
    end

    // ------------------------------------------------------------
    // Per-channel state.
    // ------------------------------------------------------------
    bioc_state_e        st_q      [NCH];
    logic [WORD_W-1:0]  obuf_q    [NCH];
    logic [WORD_W-1:0]  inBuf_q   [NCH];
    logic [DWORD_W-1:0] dbuf_q    [NCH];
    logic [PAR_W-1:0]   par_q     [NCH];
    logic [ADDR_W-1:0]  tar_q     [NCH];
    logic [WCNT_W-1:0]  wcnt_q    [NCH];
    logic [SKIP_W-1:0]  skip_q    [NCH];
    logic [STAT_W-1:0]  status_q  [NCH];
    logic [1:0]         term_q    [NCH];
    logic [1:0]         hist_q    [NCH];
    logic [NCH-1:0] dir_q, blkReq_q, half_q, single_q, inLat_q, ackPend_q;
    logic [NCH-1:0] accHold_q, outWait_q, got_q, owner, req, grantCh;
    logic [NCH-1:0] ready, busy, latch, outDone, wantStretch;

    // ------------------------------------------------------------
    // Scan slots.
    // ------------------------------------------------------------
    logic [CNT_W-1:0] slotCnt_q;
    logic [$clog2(NCH)-1:0] scanOwn_q;
    logic             slotEnd;
    assign slotEnd = (slotCnt_q >= SLOT_END && !wantStretch[scanOwn_q])
                   || slotCnt_q == SLOT_MAX;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            slotCnt_q <= '0;
            scanOwn_q <= '0;
        end else if (slotEnd) begin
            slotCnt_q <= '0;
            scanOwn_q <= scanOwn_q + 1'b1;
        end else begin
            slotCnt_q <= slotCnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Memory arbitration.
    // ------------------------------------------------------------
    always_comb begin
        grantCh = '0;
        memOut  = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (req[i]) begin
                grantCh = '0;
                grantCh[i] = memIn.grant && !memIn.prioIn;
                memOut.req = 1'b1;
                memOut.we  = (st_q[i] == ST_ISTORE);
                memOut.dbl = (st_q[i] == ST_ISTORE)
                          || (st_q[i] == ST_OFETCH);
                memOut.addr = memOut.dbl ? tar_q[i]
                            : ADDR_W'(par_q[i]);
                memOut.wdata = dbuf_q[i];
            end
        end
    end
    assign prioOut = memIn.prioIn || (|req);

    // ------------------------------------------------------------
    // Channel sequencers.
    // ------------------------------------------------------------
    for (genvar g = 0; g < NCH; g++) begin : gCh
        logic [WORD_W-1:0] rw;
        bioc_state_e       termNext;
        assign rw = memIn.rdata[WORD_W-1:0];
        assign owner[g] = (scanOwn_q == g);
        assign req[g] = st_q[g] inside {ST_FCMD, ST_FP1, ST_FP2,
                                        ST_OFETCH, ST_ISTORE};
        assign ready[g] = &hist_q[g];
        assign busy[g]  = (st_q[g] != ST_IDLE) || single_q[g];
        assign latch[g] = owner[g] && uS2_q.dataAvail && !accHold_q[g]
                       && !ackPend_q[g];
        assign outDone[g] = owner[g] && uS2_q.accepted && !outWait_q[g]
                         && (st_q[g] inside {ST_SCMD, ST_OSEND}
                             || single_q[g]);
        assign wantStretch[g] = (accHold_q[g] || ackPend_q[g]
                              || st_q[g] inside {ST_SCMD, ST_OSEND}
                              || single_q[g]);
        always_comb begin
            unique case (term_q[g])
                TERM_DATA: termNext = ST_FP1;
                TERM_CMD:  termNext = ST_FCMD;
                default:   termNext = ST_IDLE;
            endcase
        end

        // Block sequencer.
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                st_q[g] <= ST_IDLE;
                obuf_q[g] <= '0;
                dir_q[g] <= 1'b0;
                blkReq_q[g] <= 1'b0;
                par_q[g] <= '0;
                tar_q[g] <= '0;
                wcnt_q[g] <= '0;
                skip_q[g] <= '0;
                term_q[g] <= '0;
                dbuf_q[g] <= '0;
                half_q[g] <= 1'b0;
                single_q[g] <= 1'b0;
            end else begin
                if (wbWr && !busy[g]) begin
                    if (regOp(wb_adr_i, g, REG_CMD)) begin
                        obuf_q[g] <= wb_dat_i[WORD_W-1:0];
                        blkReq_q[g] <= wb_dat_i[BLOCK_BIT];
                        dir_q[g] <= wb_dat_i[DIR_BIT];
                        st_q[g] <= ST_SCMD;
                    end else if (regOp(wb_adr_i, g, REG_ODATA)) begin
                        obuf_q[g] <= wb_dat_i[WORD_W-1:0];
                        single_q[g] <= 1'b1;
                    end else if (regOp(wb_adr_i, g, REG_PADDR)) begin
                        par_q[g] <= wb_dat_i[PAR_W-1:0];
                    end
                end
                if (single_q[g] && outDone[g]) single_q[g] <= 1'b0;
                unique case (st_q[g])
                    ST_IDLE: ;
                    ST_SCMD: if (outDone[g]) begin
                        st_q[g] <= blkReq_q[g] ? ST_FP1 : ST_IDLE;
                    end
                    ST_FCMD: if (grantCh[g]) begin
                        obuf_q[g] <= rw;
                        blkReq_q[g] <= rw[BLOCK_BIT];
                        dir_q[g] <= rw[DIR_BIT];
                        par_q[g] <= par_q[g] + 1'b1;
                        st_q[g] <= ST_SCMD;
                    end
                    ST_FP1: if (grantCh[g]) begin
                        wcnt_q[g] <= rw[WCNT_W-1:0];
                        skip_q[g] <= dir_q[g] ? '0
                                   : rw[WORD_W-1:SKIP_LO];
                        par_q[g] <= par_q[g] + 1'b1;
                        st_q[g] <= ST_FP2;
                    end
                    ST_FP2: if (grantCh[g]) begin
                        tar_q[g] <= rw[ADDR_W-1:0];
                        term_q[g] <= rw[TOP_HI:TOP_LO];
                        par_q[g] <= par_q[g] + 1'b1;
                        half_q[g] <= 1'b0;
                        st_q[g] <= dir_q[g] ? ST_OFETCH : ST_IGATH;
                    end
                    ST_OFETCH: if (grantCh[g]) begin
                        dbuf_q[g] <= memIn.rdata;
                        st_q[g] <= ST_OSEND;
                    end
                    ST_OSEND: if (outDone[g]) begin
                        wcnt_q[g] <= wcnt_q[g] - 1'b1;
                        half_q[g] <= !half_q[g];
                        if (wcnt_q[g] <= WCNT_W'(1)) begin
                            st_q[g] <= termNext;
                        end else if (half_q[g]) begin
                            tar_q[g] <= tar_q[g] + ADDR_W'(2);
                            st_q[g] <= ST_OFETCH;
                        end
                    end
                    ST_IGATH: if (latch[g]) begin
                        if (skip_q[g] != '0) begin
                            skip_q[g] <= skip_q[g] - 1'b1;
                        end else begin
                            if (half_q[g]) dbuf_q[g][WORD_W-1:0] <= uS2_q.data;
                            else dbuf_q[g][DWORD_W-1:WORD_W] <= uS2_q.data;
                            half_q[g] <= !half_q[g];
                            wcnt_q[g] <= wcnt_q[g] - 1'b1;
                            if (half_q[g] || wcnt_q[g] <= WCNT_W'(1)) begin
                                st_q[g] <= ST_ISTORE;
                            end
                        end
                    end
                    ST_ISTORE: if (grantCh[g]) begin
                        tar_q[g] <= tar_q[g] + ADDR_W'(2);
                        half_q[g] <= 1'b0;
                        st_q[g] <= (wcnt_q[g] == '0) ? termNext : ST_IGATH;
                    end
                    default: st_q[g] <= ST_IDLE;
                endcase
            end
        end

        // Single-word input, status capture and handshakes.
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                inBuf_q[g] <= '0;
                inLat_q[g] <= 1'b0;
                status_q[g] <= '0;
                ackPend_q[g] <= 1'b0;
                accHold_q[g] <= 1'b0;
                outWait_q[g] <= 1'b0;
                got_q[g] <= 1'b0;
                hist_q[g] <= '0;
            end else begin
                if (owner[g] && uS2_q.statusValid)
                    status_q[g] <= uS2_q.data[STAT_W-1:0];
                if (latch[g] && st_q[g] == ST_IGATH)
                    accHold_q[g] <= 1'b1;
                else if (latch[g] && !inLat_q[g] && st_q[g] != ST_ISTORE) begin
                    inBuf_q[g] <= uS2_q.data;
                    inLat_q[g] <= 1'b1;
                end
                if (wbRd && regOp(wb_adr_i, g, REG_IDATA)
                    && ready[g] && inLat_q[g]) begin
                    inLat_q[g] <= 1'b0;
                    ackPend_q[g] <= 1'b1;
                end
                if (ackPend_q[g] && owner[g]) begin
                    ackPend_q[g] <= 1'b0;
                    accHold_q[g] <= 1'b1;
                end else if (accHold_q[g] && owner[g] && !uS2_q.dataAvail
                             && !(latch[g] && st_q[g] == ST_IGATH)) begin
                    accHold_q[g] <= 1'b0;
                end
                if (outDone[g]) outWait_q[g] <= 1'b1;
                else if (!uS2_q.accepted) outWait_q[g] <= 1'b0;
                if (owner[g] && slotEnd) begin
                    hist_q[g] <= {hist_q[g][0], got_q[g]};
                    got_q[g] <= 1'b0;
                end else if (owner[g]
                             && (uS2_q.statusValid || uS2_q.dataAvail)) begin
                    got_q[g] <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Unit bus drive, registered.
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            unitOut <= '0;
        end else begin
            unitOut.chanSel <= scanOwn_q[0];
            unitOut.dataAccepted <= accHold_q[scanOwn_q];
            unitOut.cmdHere <= st_q[scanOwn_q] == ST_SCMD
                            && !outWait_q[scanOwn_q];
            unitOut.dataHere <= (st_q[scanOwn_q] == ST_OSEND
                              || single_q[scanOwn_q])
                             && !outWait_q[scanOwn_q];
            unitOut.data <= (st_q[scanOwn_q] == ST_OSEND)
                ? (half_q[scanOwn_q] ? dbuf_q[scanOwn_q][WORD_W-1:0]
                                     : dbuf_q[scanOwn_q][DWORD_W-1:WORD_W])
                : obuf_q[scanOwn_q];
        end
    end

    // ------------------------------------------------------------
    // Register read data.
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (wbRd) begin
            wb_dat_o <= '0;
            for (int i = 0; i < NCH; i++) begin
                if (regOp(wb_adr_i, i, REG_IDATA))
                    wb_dat_o <= (ready[i] && inLat_q[i])
                        ? {8'h00, inBuf_q[i]} : REFUSED;
                if (regOp(wb_adr_i, i, REG_ISTAT))
                    wb_dat_o <= ready[i] ? {24'h00_0000, status_q[i]}
                                         : REFUSED;
                if (regOp(wb_adr_i, i, REG_CHSTAT))
                    wb_dat_o <= {8'h00, skip_q[i], 5'h00, st_q[i],
                                 ready[i], busy[i]};
            end
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    idw_refuse_a: assert property (wbRd && regOp(wb_adr_i, 0, REG_IDATA)
        && !(ready[0] && inLat_q[0]) |=> wb_dat_o == REFUSED)
        else $error("input data returned while not ready");
    accept_owner_a: assert property (unitOut.dataAccepted
        |-> $past(accHold_q[scanOwn_q]))
        else $error("data accepted without a held handshake");
    store_hold_a: assert property (st_q[0] == ST_ISTORE && !grantCh[0]
        |=> st_q[0] == ST_ISTORE && !accHold_q[0] || $past(accHold_q[0]))
        else $error("store cycle left without a grant");
    slot_min_a: assert property (slotEnd |-> slotCnt_q >= SLOT_END)
        else $error("scan slot ended early");
    slot_max_a: assert property (slotCnt_q <= SLOT_MAX)
        else $error("scan slot stretched beyond timeout");
    grant_prio_a: assert property (grantCh[1] |-> !req[0])
        else $error("grant reached lower priority channel");
    par_step_a: assert property (st_q[0] == ST_FP1 && grantCh[0]
        |=> par_q[0] == $past(par_q[0]) + 1'b1 && st_q[0] == ST_FP2)
        else $error("parameter address not advanced");
    term_idle_a: assert property (st_q[0] == ST_OSEND && outDone[0]
        && wcnt_q[0] == WCNT_W'(1) && !term_q[0][1] |=> st_q[0] == ST_IDLE)
        else $error("block did not end not busy");
    odw_busy_a: assert property (wbWr && !busy[0]
        && regOp(wb_adr_i, 0, REG_ODATA) |=> busy[0] ##1 (unitOut.dataHere
        || !$past(owner[0]) || $past(outWait_q[0])))
        else $error("single output did not go busy");

endmodule
`default_nettype wire

// *** verification/bioc_unit_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bioc_unit_model (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire bioc_pkg::bioc_unit_out_s unitOut,
    output var  bioc_pkg::bioc_unit_in_s  unitIn
);
    import bioc_pkg::*;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            unitIn <= '0;
        end else begin
            unitIn.statusValid <= 1'b1;
            unitIn.data        <= 24'h00005A;
            unitIn.accepted    <= unitOut.dataHere | unitOut.cmdHere;
            unitIn.dataAvail   <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bioc_pkg::*;
    logic           sys_clk, rst, wbCyc, wbStb, wbWe, wbAck, prioOut;
    logic [7:0]     wbAdr;
    logic [31:0]    wbDatI, wbDatO, q;
    bioc_unit_in_s  unitIn;
    bioc_unit_out_s unitOut;
    bioc_mem_in_s   memIn;
    bioc_mem_out_s  memOut;
    int             errors, samples_checked, n;
    assign memIn = '{grant: memOut.req, prioIn: 1'b0, rdata: 48'h0};
    bioc_channel #(.SLOT_CYC(4), .TMO_CYC(16)) u_bioc_channel (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .unitIn(unitIn),
        .unitOut(unitOut), .memIn(memIn), .memOut(memOut), .prioOut(prioOut));
    bioc_unit_model u_bioc_unit_model (.sys_clk(sys_clk), .rst(rst),
        .unitOut(unitOut), .unitIn(unitIn));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic summarize();
        $display("Counts: %0d checked, %0d errors", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= w;
        wbAdr  <= a;
        wbDatI <= d;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wbAck !== 1'b1 && k < 50);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge sys_clk);
        if (k >= 50) begin
            errors++;
            summarize();
        end
    endtask
    initial begin
        {rst, wbCyc, wbStb, wbWe, wbAdr, wbDatI} = '0;
        errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, 8'h14, 32'h0);
        check(q & 32'h3, 32'h0);
        bus(1'b0, 8'h0C, 32'h0);
        check(q, REFUSED);
        bus(1'b0, 8'hC0, 32'h0);
        check(q, 32'h0);
        $display("Reset and refusal test done");
        bus(1'b1, 8'h04, 32'h00123456);
        n = 0;
        while (unitOut.dataHere !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 200) errors++;
        check({8'h0, unitOut.data}, 32'h00123456);
        check({31'h0, unitOut.chanSel}, 32'h0);
        n = 0;
        do begin
            bus(1'b0, 8'h14, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 50);
        check(q & 32'h1, 32'h0);
        $display("Single output test done");
        repeat (40) @(posedge sys_clk);
        bus(1'b0, 8'h10, 32'h0);
        check(q, 32'h0000005A);
        bus(1'b0, 8'h30, 32'h0);
        check(q, 32'h0000005A);
        $display("Status test done");
        bus(1'b1, 8'h08, 32'h00000100);
        bus(1'b1, 8'h00, 32'h00C00000);
        n = 0;
        while (memOut.req !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 200) errors++;
        check({12'h0, memOut.addr}, 32'h00000100);
        check({31'h0, prioOut}, 32'h1);
        @(posedge sys_clk);
        check({12'h0, memOut.addr}, 32'h00000101);
        n = 0;
        do begin
            bus(1'b0, 8'h14, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 50);
        check(q & 32'h1, 32'h0);
        $display("Block initiation test done");
        summarize();
    end
endmodule
`default_nettype wire
